// File: hdl/evsc_consts.vh
// Constants for the event start-condition block.
// Assumes a 200 MHz controller clock and 32-bit APB.
`ifndef EVSC_CONSTS_VH
`define EVSC_CONSTS_VH

// ****************************
// Register offsets
// ****************************
`define EVSC_OFF_CTRL 8'h00
`define EVSC_OFF_SOLAR 8'h04
`define EVSC_OFF_EXT 8'h08
`define EVSC_OFF_TIME 8'h0C
`define EVSC_OFF_RATE 8'h10
`define EVSC_OFF_STATUS 8'h14

// ****************************
// Control register fields
// ****************************
`define EVSC_REGULATION_PROGRAM_SELECT_LSB 0
`define EVSC_LOADF_LSB 4
`define EVSC_GENF_LSB 8
`define EVSC_MODE_LSB 12
`define EVSC_CODE_LSB 16

// ****************************
// Reset values and codes
// ****************************
`define EVSC_EXT_ZERO 8'h50
`define EVSC_REGULATION_PROGRAM_SELECT_EVENT 3'h4
`define EVSC_FN_ON 4'h4
`define EVSC_FN_OFF 4'h5
`define EVSC_MODE_EXT 2'h2

// ****************************
// Parameter selectors shown after a code is chosen
// ****************************
`define EVSC_SHOW_SOLAR 3'h0
`define EVSC_SHOW_EXT 3'h1
`define EVSC_SHOW_TIME 3'h2
`define EVSC_SHOW_RATE 3'h3
`define EVSC_SHOW_NONE 3'h7

// ****************************
// Timing
// ****************************
`define EVSC_CLK_MHZ 200
`define EVSC_MS_PER_MIN 60000
`define EVSC_SOLAR_DELAY_MIN 6

`endif

// File: hdl/evsc_start_logic.v
// Event controller start condition, event state and terminal drive.
// Assumes voltages, time of day and qualifiers arrive on mclk_i; the
// push-button comes from a pin and is synchronised here.
//
// What this block does
// - Event controller runs only with regulation program 4, off for 0-3.
// - Terminal follows the event only when its function is 4 or 5.
// - Codes 0/1: solar open-circuit voltage above/below solar threshold.
// - Codes 2/3: external sense voltage above/below external threshold.
// - Codes 4/5: button on/off and time of day past time setting.
// - Codes 8-11 repeat every 10, 30, 60, 120 minutes after time setting.
// - Code 12: time of day past time setting, 0.0 to 23.9 hours.
// - Code 14 repeats every 0-240 minutes, code 15 every 0.0-24.0 hours.
// - Solar conditions may lag up to six minutes; logic tolerates it.
// - External threshold is offset code: 80 is 0 V, 0.1 V steps.
// - External and button conditions count only in sense input mode 2.
// - Status shows which setting belongs to the chosen start code.
// - Idle event starts when start and both qualifiers are true.
// - Active event stops on stop condition or either qualifier false.
// - Function 4 drives terminal on, function 5 off, while active.
//
// Chosen here: the register addresses and the APB slave port.
`include "evsc_consts.vh"
`default_nettype none

module evsc_start_logic #(
  parameter CYC_PER_MS = 200000,
  parameter MS_PER_MIN = 60000
) (
  input wire mclk_i,
  input wire reset_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o,
  input wire [7:0] solar_voltage_i,
  input wire [7:0] external_sense_voltage_i,
  input wire push_button_input_i,
  input wire [7:0] time_of_day_i,
  input wire stop_condition_i,
  input wire state_qualifier_i,
  input wire temp_time_qualifier_i,
  output reg event_active_o,
  output reg start_condition_o,
  output reg load_terminal_event_o,
  output reg load_terminal_on_o,
  output reg general_terminal_event_o,
  output reg general_terminal_on_o
);

  // ****************************
  // Local definitions
  // ****************************
  localparam EV_IDLE = 1'b0;
  localparam EV_ACTIVE = 1'b1;
  localparam [17:0] MS_LAST = CYC_PER_MS[17:0] - 18'h00001;
  localparam [15:0] MIN_LAST = MS_PER_MIN[15:0] - 16'h0001;

  // Interval in minutes for a repeat code, zero when not a repeat code
  function [11:0] interval_min;
    input [3:0] code;
    input [7:0] rate;
    begin
      case (code)
        4'h8: interval_min = 12'h00A;
        4'h9: interval_min = 12'h01E;
        4'hA: interval_min = 12'h03C;
        4'hB: interval_min = 12'h078;
        4'hE: interval_min = {4'h0, rate};
        4'hF: interval_min = {1'b0, rate, 3'h0} - {3'h0, rate, 1'b0};
        default: interval_min = 12'h000;
      endcase
    end
  endfunction

  // True when an output function hands the terminal to the event
  function fn_is_event;
    input [3:0] fn;
    begin
      fn_is_event = (fn == `EVSC_FN_ON) || (fn == `EVSC_FN_OFF);
    end
  endfunction

  // ****************************
  // Settings registers
  // ****************************
  reg [2:0] regulation_program_select_q;
  reg [3:0] load_terminal_function_q;
  reg [3:0] general_terminal_function_q;
  reg [1:0] sense_input_mode_q;
  reg [3:0] start_condition_code_q;
  reg [7:0] solar_threshold_q;
  reg [7:0] ext_threshold_q;
  reg [7:0] time_setting_q;
  reg [7:0] repeat_rate_q;
  reg pb_meta_q;
  reg pb_sync_q;
  reg [17:0] ms_cnt_q;
  reg [15:0] min_div_q;
  reg minute_tick_q;
  reg [11:0] rep_cnt_q;
  reg [3:0] code_seen_q;
  reg state_q;
  wire apb_setup;
  wire apb_done;
  wire wr_en;
  reg [31:0] rd_data;
  reg rd_hit;
  reg [2:0] show_sel;
  wire ev_enabled;

  assign apb_setup = psel_i && penable_i && !pready_o;
  assign apb_done = psel_i && penable_i && pready_o;
  assign wr_en = apb_done && pwrite_i;

  // ****************************
  // APB slave
  // ****************************
  // One wait state: pready rises the cycle after the access phase opens
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h00000000;
    end else begin
      pready_o <= apb_setup;
      pslverr_o <= apb_setup && !rd_hit;
      if (apb_setup && !pwrite_i) begin
        prdata_o <= rd_data;
      end else if (apb_done) begin
        prdata_o <= 32'h00000000;
      end
    end
  end

  // Read mux; status writes are ignored, unmapped gives pslverr
  always @* begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr_i)
      `EVSC_OFF_CTRL: begin
        rd_data[`EVSC_REGULATION_PROGRAM_SELECT_LSB +: 3] = regulation_program_select_q;
        rd_data[`EVSC_LOADF_LSB +: 4] = load_terminal_function_q;
        rd_data[`EVSC_GENF_LSB +: 4] = general_terminal_function_q;
        rd_data[`EVSC_MODE_LSB +: 2] = sense_input_mode_q;
        rd_data[`EVSC_CODE_LSB +: 4] = start_condition_code_q;
      end
      `EVSC_OFF_SOLAR: rd_data[7:0] = solar_threshold_q;
      `EVSC_OFF_EXT: rd_data[7:0] = ext_threshold_q;
      `EVSC_OFF_TIME: rd_data[7:0] = time_setting_q;
      `EVSC_OFF_RATE: rd_data[7:0] = repeat_rate_q;
      `EVSC_OFF_STATUS: begin
        rd_data[0] = start_condition_o;
        rd_data[1] = event_active_o;
        rd_data[2] = ev_enabled;
        rd_data[3] = pb_sync_q;
        rd_data[6:4] = show_sel;
        rd_data[7] = load_terminal_on_o;
        rd_data[8] = general_terminal_on_o;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Settings writes, taken at the completing edge
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      regulation_program_select_q <= 3'h0;
      load_terminal_function_q <= 4'h0;
      general_terminal_function_q <= 4'h0;
      sense_input_mode_q <= 2'h0;
      start_condition_code_q <= 4'h0;
      solar_threshold_q <= 8'h00;
      ext_threshold_q <= `EVSC_EXT_ZERO;
      time_setting_q <= 8'h00;
      repeat_rate_q <= 8'h00;
    end else if (wr_en) begin
      case (paddr_i)
        `EVSC_OFF_CTRL: begin
          regulation_program_select_q <= pwdata_i[`EVSC_REGULATION_PROGRAM_SELECT_LSB +: 3];
          load_terminal_function_q <= pwdata_i[`EVSC_LOADF_LSB +: 4];
          general_terminal_function_q <= pwdata_i[`EVSC_GENF_LSB +: 4];
          sense_input_mode_q <= pwdata_i[`EVSC_MODE_LSB +: 2];
          start_condition_code_q <= pwdata_i[`EVSC_CODE_LSB +: 4];
        end
        `EVSC_OFF_SOLAR: solar_threshold_q <= pwdata_i[7:0];
        `EVSC_OFF_EXT: ext_threshold_q <= pwdata_i[7:0];
        `EVSC_OFF_TIME: time_setting_q <= pwdata_i[7:0];
        `EVSC_OFF_RATE: repeat_rate_q <= pwdata_i[7:0];
        default: ;
      endcase
    end
  end

  // ****************************
  // Inputs and time base
  // ****************************
  // Button pin passes two flops before any use
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pb_meta_q <= 1'b0;
      pb_sync_q <= 1'b0;
    end else begin
      pb_meta_q <= push_button_input_i;
      pb_sync_q <= pb_meta_q;
    end
  end

  // Millisecond then minute divider; two stages keep counters small
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ms_cnt_q <= 18'h00000;
      min_div_q <= 16'h0000;
      minute_tick_q <= 1'b0;
    end else begin
      minute_tick_q <= 1'b0;
      if (ms_cnt_q == MS_LAST) begin
        ms_cnt_q <= 18'h00000;
        if (min_div_q == MIN_LAST) begin
          min_div_q <= 16'h0000;
          minute_tick_q <= 1'b1;
        end else begin
          min_div_q <= min_div_q + 16'h0001;
        end
      end else begin
        ms_cnt_q <= ms_cnt_q + 18'h00001;
      end
    end
  end

  // ****************************
  // Start condition
  // ****************************
  wire time_past;
  wire ext_ok;
  wire [11:0] interval;
  wire rep_hit;
  reg start_cond;
  assign ev_enabled = regulation_program_select_q == `EVSC_REGULATION_PROGRAM_SELECT_EVENT;
  assign time_past = time_of_day_i > time_setting_q;
  // external and button need mode 2
  assign ext_ok = sense_input_mode_q == `EVSC_MODE_EXT;
  assign interval = interval_min(start_condition_code_q, repeat_rate_q);
  // A stale count must not fire in the cycle the code changes
  assign rep_hit = minute_tick_q && (interval != 12'h000) &&
                   (code_seen_q == start_condition_code_q) &&
                   (rep_cnt_q + 12'h001 >= interval);

  // Repeat minute counter restarts when the code changes
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rep_cnt_q <= 12'h000;
      code_seen_q <= 4'h0;
    end else begin
      code_seen_q <= start_condition_code_q;
      if (code_seen_q != start_condition_code_q) begin
        rep_cnt_q <= 12'h000;
      end else if (rep_hit) begin
        rep_cnt_q <= 12'h000;
      end else if (minute_tick_q) begin
        rep_cnt_q <= rep_cnt_q + 12'h001;
      end
    end
  end

  // Per-code start level or pulse
  // solar value is used as delivered, so measurement lag is harmless
  always @* begin
    start_cond = 1'b0;
    case (start_condition_code_q)
      4'h0: start_cond = solar_voltage_i > solar_threshold_q;
      4'h1: start_cond = solar_voltage_i < solar_threshold_q;
      // external compare, both in offset code
      4'h2: start_cond = ext_ok && (external_sense_voltage_i > ext_threshold_q);
      4'h3: start_cond = ext_ok && (external_sense_voltage_i < ext_threshold_q);
      4'h4: start_cond = ext_ok && pb_sync_q && time_past;
      4'h5: start_cond = ext_ok && !pb_sync_q && time_past;
      4'h8, 4'h9, 4'hA, 4'hB: start_cond = rep_hit && time_past;
      4'hC: start_cond = time_past;
      4'hE, 4'hF: start_cond = rep_hit;
      default: start_cond = 1'b0;
    endcase
  end

  // setting that goes with the chosen code
  always @* begin
    case (start_condition_code_q)
      4'h0, 4'h1: show_sel = `EVSC_SHOW_SOLAR;
      4'h2, 4'h3: show_sel = `EVSC_SHOW_EXT;
      4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC: show_sel = `EVSC_SHOW_TIME;
      4'hE, 4'hF: show_sel = `EVSC_SHOW_RATE;
      default: show_sel = `EVSC_SHOW_NONE;
    endcase
  end

  // ****************************
  // Event state
  // ****************************
  reg state_d;
  wire quals;
  assign quals = state_qualifier_i && temp_time_qualifier_i;
  always @* begin
    state_d = state_q;
    case (state_q)
      EV_IDLE: begin
        if (ev_enabled && start_cond && quals) begin
          state_d = EV_ACTIVE;
        end
      end
      EV_ACTIVE: begin
        if (!ev_enabled || stop_condition_i || !quals) begin
          state_d = EV_IDLE;
        end
      end
      default: state_d = EV_IDLE;
    endcase
  end

  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= EV_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************
  // Outputs
  // ****************************
  // Registered so every output leaves a flop
  always @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      event_active_o <= 1'b0;
      start_condition_o <= 1'b0;
      load_terminal_event_o <= 1'b0;
      load_terminal_on_o <= 1'b0;
      general_terminal_event_o <= 1'b0;
      general_terminal_on_o <= 1'b0;
    end else begin
      event_active_o <= state_d;
      start_condition_o <= start_cond;
      // only functions 4 and 5 hand over the terminal
      load_terminal_event_o <= ev_enabled && fn_is_event(load_terminal_function_q);
      general_terminal_event_o <= ev_enabled && fn_is_event(general_terminal_function_q);
      // function 4 on, function 5 off, while active
      load_terminal_on_o <= ev_enabled && fn_is_event(load_terminal_function_q) &&
                            (state_d == (load_terminal_function_q == `EVSC_FN_ON));
      general_terminal_on_o <= ev_enabled && fn_is_event(general_terminal_function_q) &&
                               (state_d == (general_terminal_function_q == `EVSC_FN_ON));
    end
  end

endmodule
`default_nettype wire

// File: tb/evsc_props.sv
// Assertions for the event start-condition block.
// Sees top ports only; shadows CTRL and time writes.
`default_nettype none
module evsc_props (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [7:0] time_of_day_i,
  input wire logic stop_condition_i,
  input wire logic state_qualifier_i,
  input wire logic temp_time_qualifier_i,
  input wire logic event_active_o,
  input wire logic start_condition_o,
  input wire logic load_terminal_event_o,
  input wire logic load_terminal_on_o,
  input wire logic general_terminal_event_o,
  input wire logic general_terminal_on_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] ctrl_q;
  logic [7:0] tset_q;
  wire logic wr_done = psel_i && penable_i && pready_o && pwrite_i;
  wire logic [3:0] code = ctrl_q[19:16];
  wire logic late = time_of_day_i > tset_q;
  wire logic ev4 = ctrl_q[2:0] == 3'h4;
  wire logic own_ld = ev4 && (ctrl_q[7:4] == 4'h4 || ctrl_q[7:4] == 4'h5);
  wire logic own_gn = ev4 && (ctrl_q[11:8] == 4'h4 || ctrl_q[11:8] == 4'h5);
  // Shadow taken on the completing edge, as the slave does
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q <= 32'h0;
      tset_q <= 8'h0;
    end else if (wr_done && paddr_i == 8'h00) begin
      ctrl_q <= pwdata_i;
    end else if (wr_done && paddr_i == 8'h0C) begin
      tset_q <= pwdata_i[7:0];
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence setup_s; psel_i && !penable_i; endsequence
  sequence access_s; psel_i && penable_i && !pready_o; endsequence
  apb_wait_a: assert property (setup_s ##1 access_s |=> pready_o)
    else $error("apb answer late");
  apb_unmapped_a: assert property (access_s ##0 paddr_i > 8'h14 |=> pslverr_o)
    else $error("unmapped access not refused");
  regulation_program_select_gate_a: assert property (!ev4 |=> !event_active_o)
    else $error("event active outside program 4");
  load_owner_a: assert property (!own_ld |=> !load_terminal_event_o)
    else $error("load terminal taken wrongly");
  gen_owner_a: assert property (!own_gn |=> !general_terminal_event_o)
    else $error("general terminal taken wrongly");
  event_rise_a: assert property ($rose(event_active_o) |-> start_condition_o &&
    $past(state_qualifier_i) && $past(temp_time_qualifier_i))
    else $error("event rose without all conditions");
  event_stop_a: assert property (event_active_o && (stop_condition_i ||
    !state_qualifier_i || !temp_time_qualifier_i) |=> !event_active_o)
    else $error("event failed to stop");
  time_start_a: assert property (code == 4'hC |=> start_condition_o == $past(late))
    else $error("time start wrong");
  unused_code_a: assert property (code == 4'h6 || code == 4'h7 || code == 4'hD
    |=> !start_condition_o)
    else $error("unused code started");
  pulse_one_a: assert property (start_condition_o && code[3] && code[3:1] != 3'h6
    && $stable(code) |=> !start_condition_o)
    else $error("repeat start not a pulse");
  load_drive_a: assert property (load_terminal_event_o && ctrl_q[7:4] == 4'h4 &&
    $stable(ctrl_q) |-> load_terminal_on_o == event_active_o)
    else $error("load drive wrong");
  gen_drive_a: assert property (general_terminal_event_o && ctrl_q[11:8] == 4'h5 &&
    $stable(ctrl_q) |-> general_terminal_on_o == !event_active_o)
    else $error("general drive wrong");
endmodule
`default_nettype wire

// File: tb/evsc_sense_model.sv
// Far side of the sense input: a switch or a voltage source.
// Driven by the bench on the controller clock.
`default_nettype none
module evsc_sense_model (
  input wire logic mclk_i,
  input wire logic press_i,
  input wire logic [7:0] volts_i,
  output var logic push_button_o = 1'b0,
  output var logic [7:0] volts_o = 8'h50
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge mclk_i) begin
    push_button_o <= press_i;
    volts_o <= volts_i;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the event start-condition block.
// Assumes short minute ticks: 2 x 3 cycles per minute.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, reset_n_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h0, sol = 8'h0, sth = 8'h0, eth = 8'h50, vcmd = 8'h50;
  logic [7:0] tod = 8'h0, tset = 8'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic stop = 1'b0, sq = 1'b1, tq = 1'b1, press = 1'b0, err, pb;
  logic [1:0] mode = 2'h0;
  logic [7:0] ext;
  logic [31:0] prdata;
  logic pready, pslverr, ev, st, lev, lon, gev, gon;
  int miscompares = 0, n_tests = 0, cyc = 0;
  evsc_sense_model partner (.mclk_i(mclk_i), .press_i(press), .volts_i(vcmd),
    .push_button_o(pb), .volts_o(ext));
  evsc_start_logic #(.CYC_PER_MS(2), .MS_PER_MIN(3)) DUT (.mclk_i(mclk_i),
    .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .solar_voltage_i(sol), .external_sense_voltage_i(ext),
    .push_button_input_i(pb), .time_of_day_i(tod), .stop_condition_i(stop),
    .state_qualifier_i(sq), .temp_time_qualifier_i(tq), .event_active_o(ev),
    .start_condition_o(st), .load_terminal_event_o(lev), .load_terminal_on_o(lon),
    .general_terminal_event_o(gev), .general_terminal_on_o(gon));
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  // Hang guard, well above the planned run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    @(posedge mclk_i);
    // Only the hang guard may end this wait
    while (pready !== 1'b1) begin
      @(posedge mclk_i);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic ctrl(input logic [2:0] p, input logic [3:0] lf, input logic [3:0] gf,
    input logic [3:0] c);
    apb(1'b1, 8'h00, {12'h0, c, 2'h0, mode, gf, lf, 1'b0, p});
  endtask
  function automatic logic exp_start(input logic [3:0] c);
    logic t;
    logic x;
    t = tod > tset;
    x = mode == 2'h2;
    case (c)
      4'h0: return sol > sth;
      4'h1: return sol < sth;
      4'h2: return x && vcmd > eth;
      4'h3: return x && vcmd < eth;
      4'h4: return x && press && t;
      4'h5: return x && !press && t;
      4'hC: return t;
      default: return 1'b0;
    endcase
  endfunction
  function automatic logic [2:0] exp_show(input logic [3:0] c);
    case (c)
      4'h0, 4'h1: return 3'h0;
      4'h2, 4'h3: return 3'h1;
      4'h6, 4'h7, 4'hD: return 3'h7;
      4'hE, 4'hF: return 3'h3;
      default: return 3'h2;
    endcase
  endfunction
  // Count start pulses of a repeat code over a window
  task automatic pulses(input logic [3:0] c, input logic [7:0] r, input int w, input int lo,
    input int hi);
    int k;
    k = 0;
    apb(1'b1, 8'h10, {24'h0, r});
    ctrl(3'h0, 4'h0, 4'h0, c);
    repeat (w) begin
      @(posedge mclk_i);
      k += (st === 1'b1);
    end
    check("pulse count", {31'h0, k >= lo && k <= hi}, 32'h1);
  endtask
  initial begin
    logic [3:0] c;
    void'($urandom(19342));
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    apb(1'b0, 8'h08, 32'h0);
    check("ext threshold reset", rd, 32'h50);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
    // Random settings sweep over every start code
    for (int i = 0; i < 48; i++) begin
      c = 4'(i);
      sol <= 8'($urandom);
      sth <= 8'($urandom);
      vcmd <= 8'($urandom);
      eth <= 8'($urandom);
      tod <= 8'($urandom % 240);
      tset <= 8'($urandom % 240);
      press <= 1'($urandom);
      mode <= 2'($urandom % 3);
      @(posedge mclk_i);
      apb(1'b1, 8'h04, {24'h0, sth});
      apb(1'b1, 8'h08, {24'h0, eth});
      apb(1'b1, 8'h0C, {24'h0, tset});
      ctrl(3'h0, 4'h0, 4'h0, c);
      repeat (6) @(posedge mclk_i);
      if (c < 4'h8 || c == 4'hC || c == 4'hD) begin
        check("start level", {31'h0, st}, {31'h0, exp_start(c)});
      end
      apb(1'b0, 8'h14, 32'h0);
      check("setting shown", {29'h0, rd[6:4]}, {29'h0, exp_show(c)});
    end
    $display("sweep done");
    // Event life: gated by program, then stopped and qualified off
    tod <= 8'd100;
    apb(1'b1, 8'h0C, 32'd10);
    ctrl(3'h3, 4'h4, 4'h5, 4'hC);
    repeat (4) @(posedge mclk_i);
    check("event regulation_program_select 3", {30'h0, ev, lev}, 32'h0);
    ctrl(3'h4, 4'h4, 4'h5, 4'hC);
    repeat (4) @(posedge mclk_i);
    check("event terminals", {26'h0, ev, lev, lon, gev, gon, st}, 32'h3D);
    stop <= 1'b1;
    @(posedge mclk_i);
    stop <= 1'b0;
    @(posedge mclk_i);
    check("stop", {31'h0, ev}, 32'h0);
    repeat (3) @(posedge mclk_i);
    sq <= 1'b0;
    repeat (3) @(posedge mclk_i);
    check("qualifier off", {31'h0, ev}, 32'h0);
    sq <= 1'b1;
    ctrl(3'h4, 4'h6, 4'h5, 4'hC);
    repeat (3) @(posedge mclk_i);
    check("load fn 6", {31'h0, lev}, 32'h0);
    $display("event done");
    // Repeat codes, with the time gate both ways
    tod <= 8'd5;
    pulses(4'h8, 8'h0, 130, 0, 0);
    tod <= 8'd200;
    pulses(4'h8, 8'h0, 130, 2, 2);
    pulses(4'h9, 8'h0, 200, 1, 1);
    pulses(4'hA, 8'h0, 375, 1, 1);
    pulses(4'hB, 8'h0, 735, 1, 1);
    pulses(4'hE, 8'h2, 120, 9, 10);
    pulses(4'hE, 8'h0, 100, 0, 0);
    pulses(4'hF, 8'h1, 120, 3, 3);
    $display("repeat done");
    complete_run();
  end
endmodule
bind evsc_start_logic evsc_props u_props (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .time_of_day_i(time_of_day_i), .stop_condition_i(stop_condition_i),
  .state_qualifier_i(state_qualifier_i), .temp_time_qualifier_i(temp_time_qualifier_i),
  .event_active_o(event_active_o), .start_condition_o(start_condition_o),
  .load_terminal_event_o(load_terminal_event_o), .load_terminal_on_o(load_terminal_on_o),
  .general_terminal_event_o(general_terminal_event_o),
  .general_terminal_on_o(general_terminal_on_o));
`default_nettype wire
